/* File: rtl/strobe_rise.sv */
// rising-edge detector for one synchronous strobe input
`timescale 1ns/1ps
`default_nettype none
`include "updn_counter_defines.svh"
module strobe_rise (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic strobe_in,
  output logic rise
);
  logic prev_ff;

  // idle level is high so a strobe held high through reset gives no false edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prev_ff <= `STROBE_IDLE_VAL;
    end else if (ce) begin
      prev_ff <= strobe_in;
    end
  end

  assign rise = strobe_in & ~prev_ff;
endmodule : strobe_rise
`default_nettype wire

/* File: rtl/updn_counter.sv */
// four-bit presettable up/down counter with carry and borrow, rebuilt on sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "updn_counter_defines.svh"
// How it works
// - four state bits drive four count outputs; carry and borrow outputs come from two flops of their own.
// - clear input high forces count to zero, above load and counting.
// - load gate low with clear low copies the jam inputs into the count.
// - increment strobe rising edge adds one while decrement strobe is high.
// - decrement strobe rising edge subtracts one while increment strobe is high.
// - carry and borrow stay high during counting except at terminal count.
// - carry goes low at maximum count while the increment strobe is low.
// - borrow goes low at zero count while the decrement strobe is low.
// - a build parameter picks binary sixteen states or decimal zero to nine.
module updn_counter
  import updn_counter_pkg::*;
#(
  parameter bit DECIMAL_MODE = 1'b0
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic count_clear,
  input wire logic load_gate,
  input wire logic inc_strobe,
  input wire logic dec_strobe,
  input wire logic jam_in_bit0,
  input wire logic jam_in_bit1,
  input wire logic jam_in_bit2,
  input wire logic jam_in_bit3,
  output logic count_out_bit0,
  output logic count_out_bit1,
  output logic count_out_bit2,
  output logic count_out_bit3,
  output logic carry_n,
  output logic borrow_n
);
  localparam count_t MAX_VAL = DECIMAL_MODE ? `CNT_DEC_MAX : `CNT_BIN_MAX;

  count_t count_ff;
  count_t nxt_count;
  count_t jam_val;
  logic carry_n_ff;
  logic borrow_n_ff;
  logic nxt_carry_n;
  logic nxt_borrow_n;
  logic inc_rise;
  logic dec_rise;
  action_t action;

  assign jam_val = {jam_in_bit3, jam_in_bit2, jam_in_bit1, jam_in_bit0};

  strobe_rise u_inc_rise (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce),
    .strobe_in(inc_strobe),
    .rise(inc_rise)
  );

  strobe_rise u_dec_rise (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce),
    .strobe_in(dec_strobe),
    .rise(dec_rise)
  );

  // both strobes rising together means neither gate level was high first: no step
  always_comb begin
    if (count_clear) begin
      action = act_clear;
    end else if (!load_gate) begin
      action = act_load;
    end else if (inc_rise && dec_strobe && !dec_rise) begin
      action = act_up;
    end else if (dec_rise && inc_strobe && !inc_rise) begin
      action = act_down;
    end else begin
      action = act_hold;
    end
  end

  // out-of-range decimal values left by a load step upward and wrap at fifteen
  always_comb begin
    case (action)
      act_clear: nxt_count = `CNT_RESET_VAL;
      act_load: nxt_count = jam_val;
      act_up: nxt_count = (count_ff == MAX_VAL) ? `CNT_MIN_VAL : count_t'(count_ff + 1'b1);
      act_down: nxt_count = (count_ff == `CNT_MIN_VAL) ? MAX_VAL : count_t'(count_ff - 1'b1);
      act_hold: nxt_count = count_ff;
      default: nxt_count = count_ff;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      count_ff <= `CNT_RESET_VAL;
    end else if (ce) begin
      count_ff <= nxt_count;
    end
  end

  // terminal flags follow the new count and the current strobe level, so they
  // drop in the low phase of the strobe, half a strobe period after the step
  assign nxt_carry_n = !((nxt_count == MAX_VAL) && !inc_strobe);
  assign nxt_borrow_n = !((nxt_count == `CNT_MIN_VAL) && !dec_strobe);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      carry_n_ff <= `TERM_IDLE_VAL;
      borrow_n_ff <= `TERM_IDLE_VAL;
    end else if (ce) begin
      carry_n_ff <= nxt_carry_n;
      borrow_n_ff <= nxt_borrow_n;
    end
  end

  // carry and borrow idle high so they can clock a following stage directly
  assign carry_n = carry_n_ff;
  assign borrow_n = borrow_n_ff;
  assign count_out_bit0 = count_ff[0];
  assign count_out_bit1 = count_ff[1];
  assign count_out_bit2 = count_ff[2];
  assign count_out_bit3 = count_ff[3];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_up_req;
    ce && !count_clear && load_gate && inc_rise && dec_strobe && !dec_rise;
  endsequence

  sequence s_down_req;
    ce && !count_clear && load_gate && dec_rise && inc_strobe && !inc_rise;
  endsequence

  sequence s_quiet;
    ce && !count_clear && load_gate && !inc_rise && !dec_rise;
  endsequence

  // count parked on a terminal value with its own strobe low and no step pending
  sequence s_park_max;
    ce && !count_clear && load_gate && count_ff == MAX_VAL && !inc_strobe && !dec_rise;
  endsequence

  sequence s_park_min;
    ce && !count_clear && load_gate && count_ff == `CNT_MIN_VAL && !dec_strobe && !inc_rise;
  endsequence

  sequence s_up_refused;
    ce && !count_clear && load_gate && inc_rise && !dec_strobe && !dec_rise;
  endsequence

  sequence s_down_refused;
    ce && !count_clear && load_gate && dec_rise && !inc_strobe && !inc_rise;
  endsequence

  sequence s_both_rise;
    ce && !count_clear && load_gate && inc_rise && dec_rise;
  endsequence

  a_clear_zero: assert property (ce && count_clear |=> count_ff == `CNT_RESET_VAL)
    else $error("clear did not zero the count");

  a_load_jam: assert property (ce && !count_clear && !load_gate |=> count_ff == $past(jam_val))
    else $error("load did not copy jam inputs");

  a_up_step: assert property (s_up_req |=>
    count_ff == (($past(count_ff) == MAX_VAL) ? `CNT_MIN_VAL : count_t'($past(count_ff) + 1'b1)))
    else $error("increment edge did not add one");

  a_down_step: assert property (s_down_req |=>
    count_ff == (($past(count_ff) == `CNT_MIN_VAL) ? MAX_VAL : count_t'($past(count_ff) - 1'b1)))
    else $error("decrement edge did not subtract one");

  a_no_step: assert property (s_quiet |=> $stable(count_ff))
    else $error("count moved without an edge");

  a_carry_term: assert property (ce |=> carry_n == !(count_ff == MAX_VAL && !$past(inc_strobe)))
    else $error("carry does not match terminal count");

  a_borrow_term: assert property (ce |=>
    borrow_n == !(count_ff == `CNT_MIN_VAL && !$past(dec_strobe)))
    else $error("borrow does not match zero count");

  a_carry_high: assert property (ce && inc_strobe |=> carry_n)
    else $error("carry low while increment strobe high");

  a_borrow_high: assert property (ce && dec_strobe |=> borrow_n)
    else $error("borrow low while decrement strobe high");

  // a loaded value above the top is left to run out, so only in-range counts must stay there
  a_decimal_range: assert property (ce && (count_clear || load_gate) && count_ff <= MAX_VAL |=>
    count_ff <= MAX_VAL)
    else $error("count left its range");

  // a step onto a terminal value keeps the flag high until the strobe falls
  a_carry_late: assert property (s_up_req |=> carry_n)
    else $error("carry fell in the same cycle as the up step");

  a_borrow_late: assert property (s_down_req |=> borrow_n)
    else $error("borrow fell in the same cycle as the down step");

  a_carry_drop: assert property (s_park_max |=> !carry_n)
    else $error("carry high at maximum with increment strobe low");

  a_borrow_drop: assert property (s_park_min |=> !borrow_n)
    else $error("borrow high at zero with decrement strobe low");

  a_up_refused: assert property (s_up_refused |=> $stable(count_ff))
    else $error("increment edge counted while decrement strobe low");

  a_down_refused: assert property (s_down_refused |=> $stable(count_ff))
    else $error("decrement edge counted while increment strobe low");

  a_both_rise: assert property (s_both_rise |=> $stable(count_ff))
    else $error("count moved when both strobes rose together");

  a_freeze: assert property (!ce |=> $stable(count_ff) && $stable(carry_n) && $stable(borrow_n))
    else $error("state changed while clock enable low");
endmodule : updn_counter
`default_nettype wire

/* File: rtl/updn_counter_defines.svh */
// constants for the presettable up/down counter
`ifndef UPDN_COUNTER_DEFINES_SVH
`define UPDN_COUNTER_DEFINES_SVH
`define CNT_WIDTH 4
`define CNT_RESET_VAL 4'h0
`define CNT_MIN_VAL 4'h0
`define CNT_BIN_MAX 4'hf
`define CNT_DEC_MAX 4'h9
`define STROBE_IDLE_VAL 1'b1
`define TERM_IDLE_VAL 1'b1
`endif

/* File: rtl/updn_counter_pkg.sv */
// types for the presettable up/down counter
`include "updn_counter_defines.svh"
package updn_counter_pkg;
  typedef logic [`CNT_WIDTH-1:0] count_t;
  typedef enum logic [2:0] {
    act_hold,
    act_clear,
    act_load,
    act_up,
    act_down
  } action_t;
endpackage : updn_counter_pkg

/* File: test/stage_driver.sv */
// stand-in for the logic or preceding stage that drives the count strobes
`timescale 1ns/1ps
`default_nettype none
module stage_driver (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic go_up,
  input wire logic go_down,
  output logic inc_strobe,
  output logic dec_strobe
);
  // strobes idle high like a carry or borrow output, so stages chain with no gating
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      inc_strobe <= 1'b1;
      dec_strobe <= 1'b1;
    end else begin
      inc_strobe <= !go_up;
      dec_strobe <= !go_down;
    end
  end
endmodule : stage_driver
`default_nettype wire

/* File: test/updn_counter_bench.sv */
// self-checking bench for the presettable up/down counter
`timescale 1ns/1ps
`default_nettype none
module updn_counter_bench;
  import updn_counter_pkg::*;
  typedef struct packed {action_t op; count_t jam; count_t cnt; count_t dcnt;
    logic [3:0] flg;} row_t;
  logic sys_clk, nrst, ce, count_clear, load_gate, go_up, go_down, inc_strobe, dec_strobe;
  logic carry_n, borrow_n, carry_dn, borrow_dn;
  count_t jam, q, qd;
  int errors, total_checks;
  // act_hold stands for both strobes rising together, which must not count;
  // flg holds binary carry, binary borrow, decimal carry, decimal borrow
  row_t rows [9] = '{'{act_load, 4'he, 4'he, 4'he, 4'hf}, '{act_up, 4'h0, 4'hf, 4'hf, 4'hf},
    '{act_up, 4'h0, 4'h0, 4'h0, 4'h7}, '{act_down, 4'h0, 4'hf, 4'h9, 4'ha},
    '{act_down, 4'h0, 4'he, 4'h8, 4'hf}, '{act_clear, 4'h5, 4'h0, 4'h0, 4'hf},
    '{act_hold, 4'h0, 4'h0, 4'h0, 4'ha}, '{act_load, 4'h9, 4'h9, 4'h9, 4'hf},
    '{act_up, 4'h0, 4'ha, 4'h0, 4'hd}};
  stage_driver u_drv (.sys_clk, .nrst, .go_up, .go_down, .inc_strobe, .dec_strobe);
  updn_counter #(.DECIMAL_MODE(1'b0)) dut (.sys_clk, .nrst, .ce, .count_clear,
    .load_gate, .inc_strobe, .dec_strobe, .jam_in_bit0(jam[0]), .jam_in_bit1(jam[1]),
    .jam_in_bit2(jam[2]), .jam_in_bit3(jam[3]), .count_out_bit0(q[0]), .count_out_bit1(q[1]),
    .count_out_bit2(q[2]), .count_out_bit3(q[3]), .carry_n, .borrow_n);
  updn_counter #(.DECIMAL_MODE(1'b1)) dut_dec (.sys_clk, .nrst, .ce, .count_clear,
    .load_gate, .inc_strobe, .dec_strobe, .jam_in_bit0(jam[0]), .jam_in_bit1(jam[1]),
    .jam_in_bit2(jam[2]), .jam_in_bit3(jam[3]), .count_out_bit0(qd[0]), .count_out_bit1(qd[1]),
    .count_out_bit2(qd[2]), .count_out_bit3(qd[3]), .carry_n(carry_dn), .borrow_n(borrow_dn));
  task automatic check(count_t seen, count_t exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  // holds the request three cycles so the strobe stays low while the flags are read
  task automatic act(row_t r);
    @(posedge sys_clk);
    jam <= r.jam;
    count_clear <= (r.op == act_clear);
    load_gate <= !(r.op inside {act_load, act_clear});
    go_up <= (r.op inside {act_up, act_hold});
    go_down <= (r.op inside {act_down, act_hold});
    repeat (3) @(posedge sys_clk);
    count_clear <= 1'b0;
    load_gate <= 1'b1;
    go_up <= 1'b0;
    go_down <= 1'b0;
    @(negedge sys_clk);
    check({carry_n, borrow_n, carry_dn, borrow_dn}, r.flg);
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    check(q, r.cnt);
    check(qd, r.dcnt);
  endtask : act
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    errors++;
    close_out();
  end
  initial begin
    {count_clear, go_up, go_down, jam} = '0;
    load_gate = 1'b1;
    ce = 1'b1;
    nrst = 1'b0;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    foreach (rows[i]) act(rows[i]);
    // clock enable low must swallow a pending load
    @(posedge sys_clk);
    ce <= 1'b0;
    load_gate <= 1'b0;
    jam <= 4'h5;
    repeat (3) @(posedge sys_clk);
    load_gate <= 1'b1;
    @(negedge sys_clk);
    check(q, 4'ha);
    check(qd, 4'h0);
    @(posedge sys_clk);
    ce <= 1'b1;
    // each strobe rises while the other is low: both refused, then a plain up step
    @(posedge sys_clk);
    {go_up, go_down} <= 2'h3;
    repeat (3) @(posedge sys_clk);
    go_up <= 1'b0;
    repeat (4) @(posedge sys_clk);
    {go_up, go_down} <= 2'h2;
    @(negedge sys_clk);
    check(q, 4'ha);
    repeat (4) @(posedge sys_clk);
    go_up <= 1'b0;
    @(negedge sys_clk);
    check(q, 4'ha);
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    check(q, 4'hb);
    check(qd, 4'h1);
    @(posedge sys_clk);
    nrst <= 1'b0;
    @(negedge sys_clk);
    check(q, 4'h0);
    check(qd, 4'h0);
    check({carry_n, borrow_n, carry_dn, borrow_dn}, 4'hf);
    @(posedge sys_clk);
    nrst <= 1'b1;
    close_out();
  end
endmodule : updn_counter_bench
`default_nettype wire
